// ==== test_threshold_relay_peak_ctrl.sv ====
// self-checking bench for the panel meter decision logic
// assumes the source model supplies conversions and ticks
`timescale 1ns/1ps
`default_nettype none
module test_threshold_relay_peak_ctrl;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic key_escape_i = 1'b0;
  logic style = 1'b1;
  logic [15:0] swing = 16'h7fff;
  logic [15:0] hold = 16'h0;
  logic [1:0] follow = 2'h0;
  logic [5:0] policy = 6'h0;
  logic [3:0] fra = 4'h0;
  logic [31:0] thr1 = 32'h0;
  logic [31:0] thr2 = 32'h0;
  logic [31:0] hysteresis_width = 32'h0;
  logic [31:0] act = 32'h0;
  logic [31:0] rel = 32'h0;
  logic sample_i, above_range_i, below_range_i, sensor_fault_i, unit_tick_i;
  logic signed [15:0] value_i;
  logic signed [15:0] display_value_o;
  logic [1:0] relay_o, led_o, view_index_o;
  logic [2:0] show_o;
  logic above_range_flag_o, below_range_flag_o, display_overflow_flag_o;
  logic sensor_fault_flag_o, decimal_point_o;
  int mismatches = 0;
  int num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  trpc_source_model i_trpc_source_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sample_o(sample_i), .value_o(value_i), .above_o(above_range_i),
    .below_o(below_range_i), .fault_o(sensor_fault_i), .tick_o(unit_tick_i));
  trpc_top i_trpc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .sample_i(sample_i),
    .value_i(value_i), .above_range_i(above_range_i), .below_range_i(below_range_i),
    .sensor_fault_i(sensor_fault_i), .key_up_i(1'b0), .key_down_i(1'b0),
    .key_escape_i(key_escape_i), .unit_tick_i(unit_tick_i), .peak_minimum_swing_i(swing),
    .hold_ticks_i(hold), .peak_display_style_i(style), .follow_peak_i(follow),
    .policy_i(policy), .fault_relay_action_i(fra), .primary_threshold_i(thr1),
    .second_threshold_i(thr2), .hysteresis_width_i(hysteresis_width), .activation_delay_i(act),
    .release_delay_i(rel), .relay_o(relay_o), .led_o(led_o), .show_o(show_o),
    .display_value_o(display_value_o), .view_index_o(view_index_o),
    .above_range_flag_o(above_range_flag_o), .below_range_flag_o(below_range_flag_o),
    .display_overflow_flag_o(display_overflow_flag_o),
    .sensor_fault_flag_o(sensor_fault_flag_o), .decimal_point_o(decimal_point_o));
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one conversion result, then time for flags and relays to settle
  task meas(input int v, f);
    i_trpc_source_model.set_input(v[15:0], f[2:0]);
    wait_cyc(12);
  endtask
  task cfg(input int r, p, t1, t2, h, a, d);
    @(posedge clk_i);
    policy[r*3 +: 3] <= p[2:0];
    thr1[r*16 +: 16] <= t1[15:0];
    thr2[r*16 +: 16] <= t2[15:0];
    hysteresis_width[r*16 +: 16] <= h[15:0];
    act[r*16 +: 16] <= a[15:0];
    rel[r*16 +: 16] <= d[15:0];
  endtask
  // relay checks: both relays, or relay 0 alone
  task rly(input logic [1:0] e);
    chk({2'b00, relay_o}, {2'b00, e});
  endtask
  task r0(input logic e);
    chk({3'b000, relay_o[0]}, {3'b000, e});
  endtask
  task flag_case(input int v, input logic [2:0] f, input logic [3:0] exp);
    meas(v, f);
    chk({above_range_flag_o, below_range_flag_o, display_overflow_flag_o,
      sensor_fault_flag_o}, exp);
  endtask
  task escape_press;
    @(posedge clk_i);
    key_escape_i <= 1'b1;
    wait_cyc(2);
    key_escape_i <= 1'b0;
  endtask
  // state straight after reset
  task t_reset;
    chk({1'b0, show_o}, 4'h0);
    rly(2'b00);
  endtask
  // range, sensor and display span warnings at the boundaries
  task t_flags;
    flag_case(500, 3'b000, 4'b0000);
    flag_case(500, 3'b100, 4'b1000);
    flag_case(500, 3'b010, 4'b0100);
    flag_case(500, 3'b001, 4'b0001);
    flag_case(10000, 3'b000, 4'b0010);
    flag_case(-1000, 3'b000, 4'b0010);
    flag_case(9999, 3'b000, 4'b0000);
    flag_case(-999, 3'b000, 4'b0000);
  endtask
  // one threshold, on and off policies, hysteresis band
  task t_one;
    cfg(0, 1, 100, 0, 10, 0, 0);
    cfg(1, 2, 100, 0, 10, 0, 0);
    meas(200, 0);
    rly(2'b01);
    meas(95, 0);
    rly(2'b01);
    meas(80, 0);
    rly(2'b10);
    meas(105, 0);
    rly(2'b10);
  endtask
  // activation and release delays, short excursion ignored
  task t_delay;
    cfg(0, 1, 100, 0, 10, 3, 2);
    cfg(1, 0, 0, 0, 0, 0, 0);
    meas(200, 0);
    r0(1'b0);
    wait_cyc(40);
    r0(1'b1);
    i_trpc_source_model.set_input(16'sd80, 3'b000);
    wait_cyc(6);
    meas(200, 0);
    wait_cyc(20);
    r0(1'b1);
    meas(80, 0);
    wait_cyc(30);
    r0(1'b0);
  endtask
  // two thresholds in either order, inside and outside policies
  task t_two;
    cfg(0, 3, 300, 100, 5, 0, 0);
    cfg(1, 4, 100, 300, 5, 0, 0);
    meas(200, 0);
    rly(2'b01);
    meas(400, 0);
    rly(2'b10);
    meas(50, 0);
    rly(2'b10);
  endtask
  // fault actions force on, force off and keep, then unused policy
  task t_fault;
    cfg(0, 1, 100, 0, 10, 0, 0);
    cfg(1, 2, 100, 0, 10, 0, 0);
    meas(200, 0);
    @(posedge clk_i);
    fra <= 4'b0110;
    meas(200, 3'b100);
    rly(2'b10);
    fra <= 4'b0000;
    meas(200, 3'b001);
    rly(2'b10);
    meas(200, 0);
    rly(2'b01);
    cfg(0, 0, 100, 0, 10, 0, 0);
    cfg(1, 0, 100, 0, 10, 0, 0);
    wait_cyc(8);
    rly(2'b00);
  endtask
  // relay 0 follows the peak: latched, live style, timed hold
  task t_peak;
    cfg(0, 1, 500, 0, 10, 0, 0);
    @(posedge clk_i);
    follow <= 2'b01;
    swing <= 16'd100;
    meas(100, 0);
    escape_press();
    meas(800, 0);
    meas(200, 0);
    r0(1'b1);
    escape_press();
    wait_cyc(12);
    r0(1'b0);
    style <= 1'b0;
    meas(800, 0);
    meas(200, 0);
    r0(1'b0);
    hold <= 16'd3;
    meas(800, 0);
    meas(200, 0);
    r0(1'b1);
    wait_cyc(50);
    r0(1'b0);
  endtask
  // watchdog far beyond the expected run
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
  initial begin
    wait_cyc(5);
    rst_b_i <= 1'b1;
    wait_cyc(5);
    t_reset();
    t_flags();
    t_one();
    t_delay();
    t_two();
    t_fault();
    t_peak();
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== trpc_peak.sv ====
// peak detector with timed hold for the panel meter
// assumes one value per sample strobe and a timebase tick for hold timing
`timescale 1ns/1ps
`default_nettype none
module trpc_peak (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_i,
  input wire logic signed [trpc_pkg::VAL_W-1:0] value_i,
  input wire logic [trpc_pkg::VAL_W-1:0] peak_minimum_swing_i,
  input wire logic [trpc_pkg::CNT_W-1:0] hold_ticks_i,
  input wire logic peak_display_style_i,
  input wire logic tick_i,
  input wire logic escape_i,
  output logic signed [trpc_pkg::VAL_W-1:0] peak_value_o,
  output logic peak_showing_o
);
  logic signed [trpc_pkg::VAL_W-1:0] top_reg, top_next;
  logic signed [trpc_pkg::VAL_W-1:0] peak_reg, peak_next;
  logic [trpc_pkg::CNT_W-1:0] hold_reg, hold_next;
  logic show_reg, show_next;
  logic signed [trpc_pkg::VAL_W:0] drop;
  logic found;

  // rise then fall by the minimum swing marks a peak
  always_comb begin
    drop = {top_reg[trpc_pkg::VAL_W-1], top_reg} - {value_i[trpc_pkg::VAL_W-1], value_i};
    found = sample_i && (drop >= $signed({1'b0, peak_minimum_swing_i}));
    top_next = top_reg;
    if (sample_i) begin
      if (found || value_i > top_reg) begin
        top_next = value_i;
      end
    end
    peak_next = peak_reg;
    hold_next = hold_reg;
    show_next = show_reg;
    if (found && (hold_ticks_i != '0 || peak_display_style_i)) begin
      peak_next = top_reg;
      hold_next = '0;
      show_next = 1'b1;
    end else if (show_reg) begin
      if (hold_ticks_i == '0) begin
        if (escape_i || !peak_display_style_i) begin
          show_next = 1'b0;
        end
      end else if (tick_i) begin
        hold_next = hold_reg + 1'b1;
        if (hold_reg + 1'b1 >= hold_ticks_i) begin
          show_next = 1'b0;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      top_reg <= '0;
      peak_reg <= '0;
      hold_reg <= '0;
      show_reg <= 1'b0;
    end else begin
      top_reg <= top_next;
      peak_reg <= peak_next;
      hold_reg <= hold_next;
      show_reg <= show_next;
    end
  end

  assign peak_value_o = peak_reg;
  assign peak_showing_o = show_reg;
endmodule
`default_nettype wire

// ==== trpc_pkg.sv ====
// package of constants and types for the threshold relay and peak logic
// assumes a 200 MHz system clock and 16-bit signed display-scaled values
package trpc_pkg;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned N_RELAY = 2;
  localparam int unsigned CNT_W = 16;
  // display span limits
  localparam logic signed [VAL_W-1:0] DISP_MIN = -16'sd999;
  localparam logic signed [VAL_W-1:0] DISP_MAX = 16'sd9999;
  // quick view window and identity splash, in milliseconds
  localparam int unsigned QUICK_MS = 5000;
  localparam int unsigned SPLASH_MS = 2000;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned QUICK_CYC = QUICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned SPLASH_CYC = SPLASH_MS * 1000 * CLK_MHZ;
  // flash half period of the peak decimal point, in milliseconds
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] RST_SYNC = 2'h0;
  // what the display shows
  typedef enum logic [2:0] {
    TRPC_SHOW_IDENT, TRPC_SHOW_VALUE, TRPC_SHOW_PEAK, TRPC_SHOW_ABOVE,
    TRPC_SHOW_BELOW, TRPC_SHOW_FAULT, TRPC_SHOW_OVERFLOW, TRPC_SHOW_THRESH
  } trpc_show_t;
  // switch policy per relay
  typedef enum logic [2:0] {
    TRPC_POL_UNUSED, TRPC_POL_ON, TRPC_POL_OFF, TRPC_POL_IN, TRPC_POL_OUT
  } trpc_policy_t;
  // fault action per relay
  typedef enum logic [1:0] {
    TRPC_FLT_KEEP, TRPC_FLT_ON, TRPC_FLT_OFF
  } trpc_fault_t;
endpackage

// ==== trpc_relay.sv ====
// one relay channel: zone decision, hysteresis, on and off delays, fault action
// assumes a timebase tick chosen by the time unit setting
`timescale 1ns/1ps
`default_nettype none
module trpc_relay (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic signed [trpc_pkg::VAL_W-1:0] value_i,
  input wire logic fault_i,
  input wire logic tick_i,
  input wire trpc_pkg::trpc_policy_t policy_i,
  input wire trpc_pkg::trpc_fault_t fault_relay_action_i,
  input wire logic signed [trpc_pkg::VAL_W-1:0] primary_threshold_i,
  input wire logic signed [trpc_pkg::VAL_W-1:0] second_threshold_i,
  input wire logic [trpc_pkg::VAL_W-1:0] hysteresis_width_i,
  input wire logic [trpc_pkg::CNT_W-1:0] activation_delay_i,
  input wire logic [trpc_pkg::CNT_W-1:0] release_delay_i,
  output logic relay_o
);
  logic relay_reg, relay_next;
  logic [trpc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic signed [trpc_pkg::VAL_W+1:0] v, lo, hi, h;
  logic in_a, out_b, want, decided;
  logic [trpc_pkg::CNT_W-1:0] dly;

  // zone classification against the border values
  always_comb begin
    v = {{2{value_i[trpc_pkg::VAL_W-1]}}, value_i};
    h = {2'b00, hysteresis_width_i};
    if (primary_threshold_i <= second_threshold_i || policy_i == trpc_pkg::TRPC_POL_ON ||
        policy_i == trpc_pkg::TRPC_POL_OFF) begin
      lo = {{2{primary_threshold_i[trpc_pkg::VAL_W-1]}}, primary_threshold_i};
      hi = {{2{second_threshold_i[trpc_pkg::VAL_W-1]}}, second_threshold_i};
    end else begin
      lo = {{2{second_threshold_i[trpc_pkg::VAL_W-1]}}, second_threshold_i};
      hi = {{2{primary_threshold_i[trpc_pkg::VAL_W-1]}}, primary_threshold_i};
    end
    in_a = 1'b0;
    out_b = 1'b0;
    case (policy_i)
      // one threshold: zone A above threshold plus hysteresis
      trpc_pkg::TRPC_POL_ON, trpc_pkg::TRPC_POL_OFF: begin
        in_a = v > lo + h;
        out_b = v < lo - h;
      end
      // two thresholds: zone A between them, one hysteresis for both
      trpc_pkg::TRPC_POL_IN, trpc_pkg::TRPC_POL_OUT: begin
        in_a = (v > lo + h) && (v < hi - h);
        out_b = (v < lo - h) || (v > hi + h);
      end
      default: begin
        in_a = 1'b0;
        out_b = 1'b0;
      end
    endcase
    decided = in_a || out_b;
    want = in_a ? (policy_i == trpc_pkg::TRPC_POL_ON || policy_i == trpc_pkg::TRPC_POL_IN)
                : (policy_i == trpc_pkg::TRPC_POL_OFF || policy_i == trpc_pkg::TRPC_POL_OUT);
    dly = want ? activation_delay_i : release_delay_i;
  end

  // delay counter and relay state
  always_comb begin
    relay_next = relay_reg;
    cnt_next = '0;
    if (policy_i == trpc_pkg::TRPC_POL_UNUSED) begin
      relay_next = 1'b0;
    end else if (fault_i) begin
      case (fault_relay_action_i)
        trpc_pkg::TRPC_FLT_ON: relay_next = 1'b1;
        trpc_pkg::TRPC_FLT_OFF: relay_next = 1'b0;
        default: relay_next = relay_reg;
      endcase
    end else if (decided && want != relay_reg) begin
      cnt_next = cnt_reg;
      if (dly == '0) begin
        relay_next = want;
        cnt_next = '0;
      end else if (tick_i) begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= dly) begin
          relay_next = want;
          cnt_next = '0;
        end
      end
    end
    // leaving the zone early drops the count, so the relay holds
  end

  // registers; relay starts released
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      relay_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      relay_reg <= relay_next;
      cnt_reg <= cnt_next;
    end
  end

  assign relay_o = relay_reg;
endmodule
`default_nettype wire

// ==== trpc_source_model.sv ====
// measurement source model: periodic conversions and time-unit ticks
// assumes the bench sets each new result through set_input
`timescale 1ns/1ps
`default_nettype none
module trpc_source_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic sample_o,
  output logic signed [15:0] value_o,
  output logic above_o,
  output logic below_o,
  output logic fault_o,
  output logic tick_o
);
  logic [3:0] phase, tdiv;
  // first conversion well after reset, then one every 4 cycles; tick every 10
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= 4'h0;
      tdiv <= 4'h0;
      sample_o <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      phase <= (phase == 4'hf) ? 4'hc : phase + 4'h1;
      sample_o <= (phase == 4'hf);
      tdiv <= (tdiv == 4'h9) ? 4'h0 : tdiv + 4'h1;
      tick_o <= (tdiv == 4'h9);
    end
  end
  // new result and range flags, changed just after a clock edge
  task set_input(input logic signed [15:0] v, input logic [2:0] flags);
    @(posedge clk_i);
    value_o <= v;
    {above_o, below_o, fault_o} <= flags;
  endtask
  initial begin
    value_o = 16'h0;
    {above_o, below_o, fault_o} = 3'h0;
  end
endmodule
`default_nettype wire

// ==== trpc_top.sv ====
// panel meter decision logic: range warnings, peak hold, relays and quick view
// assumes measurement values arrive with a sample strobe on clk_i
// Operation
// - at power-up show identity and version, then go to measuring
// - out of permissible range shows above or below range warning
// - sensor fault shows the sensor fault warning instead of value
// - in range but outside -999..9999 shows the display overflow warning; code shows the peak instead while one is held
// - up or down key shows thresholds; next press within 5 s advances
// - measuring and outputs keep running during configuration
// - peak counts only after a rise then a fall of the minimum swing
// - peak held for display time; new peak replaces and restarts timer
// - when hold expires with no new peak, live value shows again
// - zero time: latch style holds until escape, live style no hold
// - rightmost decimal point flashes while a peak is shown
// - each relay follows live value or peak value by choice
// - policy selects relay unused, one threshold or two thresholds
// - relay changes only past a border held longer than the delay
// - zero delays switch the relay at once on crossing a border
// - positive delays: on after activation delay, off after release
// - shorter stay in a zone than the delay keeps relay state
// - one threshold: relay on or off in zone A, opposite in B
// - fault action forces relay on, off or leaves it alone
// - two thresholds: on inside or outside per policy, off otherwise
// - zone between thresholds found whichever threshold is larger
// - one hysteresis, delay pair, policy, fault action per relay; one time unit tick shared by both
`timescale 1ns/1ps
`default_nettype none
module trpc_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_i,
  input wire logic signed [trpc_pkg::VAL_W-1:0] value_i,
  input wire logic above_range_i,
  input wire logic below_range_i,
  input wire logic sensor_fault_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_escape_i,
  input wire logic unit_tick_i,
  input wire logic [trpc_pkg::VAL_W-1:0] peak_minimum_swing_i,
  input wire logic [trpc_pkg::CNT_W-1:0] hold_ticks_i,
  input wire logic peak_display_style_i,
  input wire logic [trpc_pkg::N_RELAY-1:0] follow_peak_i,
  input wire logic [trpc_pkg::N_RELAY*3-1:0] policy_i,
  input wire logic [trpc_pkg::N_RELAY*2-1:0] fault_relay_action_i,
  input wire logic [trpc_pkg::N_RELAY*trpc_pkg::VAL_W-1:0] primary_threshold_i,
  input wire logic [trpc_pkg::N_RELAY*trpc_pkg::VAL_W-1:0] second_threshold_i,
  input wire logic [trpc_pkg::N_RELAY*trpc_pkg::VAL_W-1:0] hysteresis_width_i,
  input wire logic [trpc_pkg::N_RELAY*trpc_pkg::CNT_W-1:0] activation_delay_i,
  input wire logic [trpc_pkg::N_RELAY*trpc_pkg::CNT_W-1:0] release_delay_i,
  output logic [trpc_pkg::N_RELAY-1:0] relay_o,
  output logic [trpc_pkg::N_RELAY-1:0] led_o,
  output logic [2:0] show_o,
  output logic signed [trpc_pkg::VAL_W-1:0] display_value_o,
  output logic [1:0] view_index_o,
  output logic above_range_flag_o,
  output logic below_range_flag_o,
  output logic display_overflow_flag_o,
  output logic sensor_fault_flag_o,
  output logic decimal_point_o
);
  logic [1:0] sync_reg;
  logic rst_b;
  logic signed [trpc_pkg::VAL_W-1:0] live_reg, live_next;
  logic hi_reg, hi_next, lo_reg, lo_next, ov_reg, ov_next, se_reg, se_next;
  logic [31:0] splash_reg, splash_next;
  logic [31:0] quick_reg, quick_next;
  logic [1:0] view_reg, view_next;
  logic quick_on_reg, quick_on_next;
  logic keys_reg, keys_next;
  logic [31:0] flash_reg, flash_next;
  logic dp_reg, dp_next;
  logic [2:0] show_reg, show_next;
  logic signed [trpc_pkg::VAL_W-1:0] disp_reg, disp_next;
  logic signed [trpc_pkg::VAL_W-1:0] peak_value;
  logic peak_showing;
  logic range_fault;
  logic key_edge;

  // reset release through two flip-flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_reg <= trpc_pkg::RST_SYNC;
    end else begin
      sync_reg <= {sync_reg[0], 1'b1};
    end
  end
  assign rst_b = sync_reg[1];

  // range classification of each sample, kept in flags
  always_comb begin
    live_next = live_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    ov_next = ov_reg;
    se_next = se_reg;
    if (sample_i) begin
      live_next = value_i;
      se_next = sensor_fault_i;
      hi_next = above_range_i && !sensor_fault_i;
      lo_next = below_range_i && !above_range_i && !sensor_fault_i;
      ov_next = !above_range_i && !below_range_i && !sensor_fault_i &&
                (value_i < trpc_pkg::DISP_MIN || value_i > trpc_pkg::DISP_MAX);
    end
  end

  // measurement registers, never stalled by configuration
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      live_reg <= '0;
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
      ov_reg <= 1'b0;
      se_reg <= 1'b0;
    end else begin
      live_reg <= live_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      ov_reg <= ov_next;
      se_reg <= se_next;
    end
  end

  assign range_fault = hi_reg || lo_reg || se_reg;

  // peak detection and hold
  trpc_peak u_peak (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .sample_i(sample_i && !range_fault),
    .value_i(value_i),
    .peak_minimum_swing_i(peak_minimum_swing_i),
    .hold_ticks_i(hold_ticks_i),
    .peak_display_style_i(peak_display_style_i),
    .tick_i(unit_tick_i),
    .escape_i(key_escape_i),
    .peak_value_o(peak_value),
    .peak_showing_o(peak_showing)
  );

  // one relay channel per output
  genvar g;
  generate
    for (g = 0; g < trpc_pkg::N_RELAY; g++) begin : g_relay
      logic signed [trpc_pkg::VAL_W-1:0] src;
      // relay source: live or peak value
      assign src = (follow_peak_i[g] && peak_showing) ? peak_value : live_reg;
      trpc_relay u_relay (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .value_i(src),
        .fault_i(range_fault),
        .tick_i(unit_tick_i),
        .policy_i(trpc_pkg::trpc_policy_t'(policy_i[g*3 +: 3])),
        .fault_relay_action_i(trpc_pkg::trpc_fault_t'(fault_relay_action_i[g*2 +: 2])),
        .primary_threshold_i(primary_threshold_i[g*trpc_pkg::VAL_W +: trpc_pkg::VAL_W]),
        .second_threshold_i(second_threshold_i[g*trpc_pkg::VAL_W +: trpc_pkg::VAL_W]),
        .hysteresis_width_i(hysteresis_width_i[g*trpc_pkg::VAL_W +: trpc_pkg::VAL_W]),
        .activation_delay_i(activation_delay_i[g*trpc_pkg::CNT_W +: trpc_pkg::CNT_W]),
        .release_delay_i(release_delay_i[g*trpc_pkg::CNT_W +: trpc_pkg::CNT_W]),
        .relay_o(relay_o[g])
      );
      assign led_o[g] = relay_o[g];
    end
  endgenerate

  // splash timer, quick view of thresholds and decimal point flash
  always_comb begin
    keys_next = key_up_i || key_down_i;
    key_edge = keys_next && !keys_reg;
    splash_next = splash_reg;
    if (splash_reg < trpc_pkg::SPLASH_CYC) begin
      splash_next = splash_reg + 32'h1;
    end
    quick_on_next = quick_on_reg;
    quick_next = quick_reg;
    view_next = view_reg;
    if (splash_reg >= trpc_pkg::SPLASH_CYC) begin
      if (key_edge) begin
        if (quick_on_reg) begin
          view_next = (view_reg + 2'h1 >= 2'(trpc_pkg::N_RELAY)) ? 2'h0 : view_reg + 2'h1;
        end else begin
          view_next = 2'h0;
        end
        quick_on_next = 1'b1;
        quick_next = '0;
      end else if (quick_on_reg) begin
        quick_next = quick_reg + 32'h1;
        if (quick_reg + 32'h1 >= trpc_pkg::QUICK_CYC) begin
          quick_on_next = 1'b0;
        end
      end
    end
    flash_next = '0;
    dp_next = 1'b0;
    if (peak_showing) begin
      flash_next = flash_reg + 32'h1;
      dp_next = dp_reg;
      if (flash_reg + 32'h1 >= trpc_pkg::FLASH_CYC) begin
        flash_next = '0;
        dp_next = !dp_reg;
      end
    end
  end

  // display selection in priority order
  always_comb begin
    show_next = 3'(trpc_pkg::TRPC_SHOW_VALUE);
    disp_next = live_reg;
    if (splash_reg < trpc_pkg::SPLASH_CYC) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_IDENT);
      disp_next = '0;
    end else if (quick_on_reg) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_THRESH);
      disp_next = primary_threshold_i[view_reg*trpc_pkg::VAL_W +: trpc_pkg::VAL_W];
    end else if (se_reg) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_FAULT);
    end else if (hi_reg) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_ABOVE);
    end else if (lo_reg) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_BELOW);
    end else if (peak_showing) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_PEAK);
      disp_next = peak_value;
    end else if (ov_reg) begin
      show_next = 3'(trpc_pkg::TRPC_SHOW_OVERFLOW);
    end
  end

  // ui and display registers
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      keys_reg <= 1'b0;
      splash_reg <= '0;
      quick_reg <= '0;
      quick_on_reg <= 1'b0;
      view_reg <= 2'h0;
      flash_reg <= '0;
      dp_reg <= 1'b0;
      show_reg <= 3'(trpc_pkg::TRPC_SHOW_IDENT);
      disp_reg <= '0;
    end else begin
      keys_reg <= keys_next;
      splash_reg <= splash_next;
      quick_reg <= quick_next;
      quick_on_reg <= quick_on_next;
      view_reg <= view_next;
      flash_reg <= flash_next;
      dp_reg <= dp_next;
      show_reg <= show_next;
      disp_reg <= disp_next;
    end
  end

  assign show_o = show_reg;
  assign display_value_o = disp_reg;
  assign view_index_o = view_reg;
  assign above_range_flag_o = hi_reg;
  assign below_range_flag_o = lo_reg;
  assign display_overflow_flag_o = ov_reg;
  assign sensor_fault_flag_o = se_reg;
  assign decimal_point_o = dp_reg;
endmodule
`default_nettype wire

// ==== trpc_top_properties.sv ====
// port-level checker for the panel meter decision logic
// assumes it is bound to trpc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module trpc_top_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sample_i,
  input wire logic signed [15:0] value_i,
  input wire logic above_range_i,
  input wire logic below_range_i,
  input wire logic sensor_fault_i,
  input wire logic [1:0] follow_peak_i,
  input wire logic [5:0] policy_i,
  input wire logic [3:0] fault_relay_action_i,
  input wire logic [31:0] primary_threshold_i,
  input wire logic [31:0] hysteresis_width_i,
  input wire logic [31:0] activation_delay_i,
  input wire logic [31:0] release_delay_i,
  input wire logic [1:0] relay_o,
  input wire logic [1:0] led_o,
  input wire logic [2:0] show_o,
  input wire logic above_range_flag_o,
  input wire logic below_range_flag_o,
  input wire logic display_overflow_flag_o,
  input wire logic sensor_fault_flag_o
);
  logic flt_any, ovf_now, hi_zone0, fast0;
  logic signed [17:0] border_hi0;
  logic [9:0] since_rst_reg;
  // helper conditions for the overflow flag and relay 0
  assign flt_any = above_range_flag_o | below_range_flag_o | sensor_fault_flag_o;
  assign ovf_now = (value_i > trpc_pkg::DISP_MAX) || (value_i < trpc_pkg::DISP_MIN);
  assign border_hi0 = 18'(signed'(primary_threshold_i[15:0])) + 18'(hysteresis_width_i[15:0]);
  assign hi_zone0 = 18'(value_i) > border_hi0;
  assign fast0 = ~|{activation_delay_i[15:0], release_delay_i[15:0]};
  // saturating cycle count since reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) since_rst_reg <= 10'h0;
    else if (since_rst_reg != 10'h3ff) since_rst_reg <= since_rst_reg + 10'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_LED_FOLLOWS_RELAY: assert property (led_o == relay_o)
    else $error("indicator differs from relay");
  AST_IDENT_FIRST: assert property (since_rst_reg < 10'h3e8 |-> show_o == 3'h0)
    else $error("identity not shown after reset");
  AST_RELEASED_AFTER_RESET: assert property ($rose(rst_b_i) |-> relay_o == 2'h0 ##1 relay_o == 2'h0)
    else $error("relay energised right after reset");
  AST_ABOVE_FLAG: assert property (sample_i && above_range_i && !sensor_fault_i |=> above_range_flag_o)
    else $error("above range flag missing");
  AST_BELOW_FLAG: assert property (sample_i && below_range_i && !above_range_i && !sensor_fault_i
    |=> below_range_flag_o)
    else $error("below range flag missing");
  AST_SENSOR_FLAG: assert property (sample_i && sensor_fault_i |=> sensor_fault_flag_o)
    else $error("sensor fault flag missing");
  AST_OVERFLOW_FLAG: assert property (sample_i && !above_range_i && !below_range_i && !sensor_fault_i |=> display_overflow_flag_o == $past(ovf_now))
    else $error("overflow flag wrong");
  AST_ZERO_DELAY_ON: assert property ((policy_i[2:0] == 3'h1 && fast0 && hi_zone0 && !flt_any && !follow_peak_i[0])[*8] |-> relay_o[0])
    else $error("relay not on without delay");
  AST_FAULT_ACTION: assert property ((flt_any && policy_i[2:0] != 3'h0 && fault_relay_action_i[1:0] != 2'h0 && $stable(fault_relay_action_i))[*3] |-> relay_o[0] == (fault_relay_action_i[1:0] == 2'h1))
    else $error("fault action not applied");
  AST_UNUSED_OFF: assert property ((policy_i[2:0] == 3'h0 && !flt_any)[*3] |-> !relay_o[0])
    else $error("unused relay energised");
  COV_RELAY_ON: cover property ($rose(relay_o[0]));
  COV_ABOVE: cover property ($rose(above_range_flag_o));
  COV_OVERFLOW: cover property ($rose(display_overflow_flag_o));
endmodule
bind trpc_top trpc_top_properties i_trpc_top_properties (.clk_i, .rst_b_i, .sample_i, .value_i,
  .above_range_i, .below_range_i, .sensor_fault_i, .follow_peak_i, .policy_i,
  .fault_relay_action_i, .primary_threshold_i, .hysteresis_width_i, .activation_delay_i,
  .release_delay_i, .relay_o, .led_o, .show_o, .above_range_flag_o, .below_range_flag_o,
  .display_overflow_flag_o, .sensor_fault_flag_o);
`default_nettype wire
